//--- inc/fpfp_pkg.sv
// Package for the four-pair fault policy block: offsets, fields, timing, carriers
package fpfp_pkg;
  localparam logic [7:0] CMD_FAULT_CFG = 8'h2d;
  localparam logic [7:0] FAULT_CFG_RESET = 8'h00;
  localparam int CURRENT_LIMIT_FAULT_LSB = 6;
  localparam int PCUT_LSB = 4;
  localparam int SUM_LSB = 2;
  localparam int DCDT_LSB = 0;
  localparam int NUM_PORTS = 2;
  // Current codes count half milliamps, so the 75 mA re-enable level fits in a byte
  localparam logic [7:0] CUR_CODE_4P5 = 8'h09;
  localparam logic [7:0] CUR_CODE_6P5 = 8'h0d;
  localparam logic [7:0] CUR_CODE_75 = 8'h96;
  localparam int CLK_PERIOD_NS = 100;
  localparam int DROPOUT_TIME_US = 320;
  localparam int MPS_TIME_US = 60;
  localparam int DROPOUT_CYC = (DROPOUT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int MPS_CYC = (MPS_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int QUAL_CYC = DROPOUT_CYC + MPS_CYC;
  localparam int CNT_W = 13;
  typedef struct packed {
    logic current_limit_fault_fault;
    logic pcut_fault;
    logic sum_pcut_fault;
    logic [7:0] current;
  } fpfp_chan_s;
  typedef struct packed {
    logic turn_on;
    logic auto_mode;
    logic single_sig;
    logic [3:0] class_assigned;
  } fpfp_port_s;
endpackage

//--- rtl/fpfp_core.sv
// Four-pair fault policy: config register, shutdown policy, disconnect qualification
// Function
// - Register 0x2D, eight bits, resets zero
// - Four two-bit fields, one bit per port
// - Current-limit policy one kills both channels
// - Power-cut policy one kills both channels
// - Auto mode sets policy bits for single-signature
// - Summed policing bit enables combined power check
// - Current-limit faults always monitored
// - Single-signature turn-on forces summed policing
// - Threshold bit selects 4.5 or 6.5 mA
// - Dual-signature turn-on sets threshold bit, per port
// - Dual-signature low channel dropped alone
// - Single-signature threshold bit from assigned class
// - Low class single-signature drops one channel
// - Parked odd channel back once its partner is above 75 mA
// - High class keeps both until both low
module fpfp_core (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  input wire fpfp_pkg::fpfp_port_s [1:0] port_in,
  input wire logic [1:0] port_powered,
  input wire fpfp_pkg::fpfp_chan_s [3:0] chan_in,
  output logic [3:0] chan_disable,
  output logic [3:0] chan_low_current
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic [3:0] dis;
    logic [3:0] low;
    logic [3:0] parked;
    logic [3:0] off;
    logic [3:0][12:0] cnt;
  } fpfp_state_s;

  fpfp_state_s st_reg;
  fpfp_state_s st_next;
  logic [3:0] below;
  logic [3:0] qualified;

  // Threshold compare and window qualification per channel
  for (genvar c = 0; c < 4; c++)
  begin : g_chan
    localparam int P = c / 2;
    assign below[c] = st_reg.cfg[fpfp_pkg::DCDT_LSB + P] ?
      (chan_in[c].current < fpfp_pkg::CUR_CODE_4P5) :
      (chan_in[c].current < fpfp_pkg::CUR_CODE_6P5);
    assign qualified[c] = (st_reg.cnt[c] >= 13'(fpfp_pkg::QUAL_CYC));
  end

  // Next-state logic for register, policy and disconnect
  always_comb
  begin
    logic [3:0] fault_kill;
    logic [7:0] cfg_n;
    fault_kill = '0;
    cfg_n = st_reg.cfg;
    st_next = st_reg;
    if (cmd_wr && cmd_code == fpfp_pkg::CMD_FAULT_CFG)
    begin
      cfg_n = cmd_wdata;
    end
    for (int p = 0; p < fpfp_pkg::NUM_PORTS; p++)
    begin
      if (port_in[p].turn_on)
      begin
        if (port_in[p].single_sig)
        begin
          cfg_n[fpfp_pkg::SUM_LSB + p] = 1'b1;
          if (port_in[p].auto_mode)
          begin
            cfg_n[fpfp_pkg::CURRENT_LIMIT_FAULT_LSB + p] = 1'b1;
            cfg_n[fpfp_pkg::PCUT_LSB + p] = 1'b1;
          end
          cfg_n[fpfp_pkg::DCDT_LSB + p] = (port_in[p].class_assigned >= 4'h5);
        end
        else
        begin
          cfg_n[fpfp_pkg::DCDT_LSB + p] = 1'b1;
        end
      end
    end
    st_next.cfg = cfg_n;
    for (int c = 0; c < 4; c++)
    begin
      int p;
      int o;
      p = c / 2;
      o = c ^ 1;
      // Fault shutdown, current-limit watched whatever the summed bits say
      if (chan_in[c].current_limit_fault_fault)
      begin
        fault_kill[c] = 1'b1;
        if (st_reg.cfg[fpfp_pkg::CURRENT_LIMIT_FAULT_LSB + p]) fault_kill[o] = 1'b1;
      end
      if (chan_in[c].pcut_fault)
      begin
        fault_kill[c] = 1'b1;
        if (st_reg.cfg[fpfp_pkg::PCUT_LSB + p]) fault_kill[o] = 1'b1;
      end
      if (chan_in[c].sum_pcut_fault && st_reg.cfg[fpfp_pkg::SUM_LSB + p])
      begin
        fault_kill[c] = 1'b1;
        fault_kill[o] = 1'b1;
      end
    end
    for (int c = 0; c < 4; c++)
    begin
      int p;
      int o;
      logic hi;
      p = c / 2;
      o = c ^ 1;
      hi = st_reg.cfg[fpfp_pkg::DCDT_LSB + p];
      st_next.cnt[c] = (below[c] && !st_reg.parked[c] && port_powered[p]) ?
        (qualified[c] ? st_reg.cnt[c] : st_reg.cnt[c] + 13'h1) : 13'h0;
      st_next.low[c] = qualified[c];
      if (!port_powered[p])
      begin
        st_next.dis[c] = 1'b0;
        st_next.parked[c] = 1'b0;
      end
      else
      begin
        if (!port_in[p].single_sig)
        begin
          if (qualified[c]) st_next.dis[c] = 1'b1;
        end
        else if (hi)
        begin
          if (qualified[c] && qualified[o]) st_next.dis[c] = 1'b1;
        end
        else if (c % 2 == 1)
        begin
          // Odd channel parked when either pair goes low
          if (!st_reg.parked[c] && (below[c] || below[o]))
            st_next.parked[c] = 1'b1;
          else if (st_reg.parked[c] && chan_in[o].current > fpfp_pkg::CUR_CODE_75)
            st_next.parked[c] = 1'b0;
        end
        else if (qualified[c])
        begin
          st_next.dis[c] = 1'b1;
        end
        if (fault_kill[c]) st_next.dis[c] = 1'b1;
      end
    end
    st_next.rdata = (cmd_code == fpfp_pkg::CMD_FAULT_CFG) ? st_reg.cfg : 8'h00;
    // Channel-off output registered so the pin comes straight from a flop
    st_next.off = st_next.dis | st_next.parked;
  end

  // State register with clock enable
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.cfg <= fpfp_pkg::FAULT_CFG_RESET;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  assign cmd_rdata = st_reg.rdata;
  assign chan_disable = st_reg.off;
  assign chan_low_current = st_reg.low;

  // Checks: multi-step causes kept as named sequences
  sequence current_limit_fault_hit_s(int c);
    clk_en && port_powered[c/2] && chan_in[c].current_limit_fault_fault && st_reg.cfg[fpfp_pkg::CURRENT_LIMIT_FAULT_LSB + c/2];
  endsequence
  sequence park_cause_s;
    clk_en && port_powered[0] && port_in[0].single_sig && !st_reg.cfg[fpfp_pkg::DCDT_LSB]
      && !st_reg.parked[1] && (below[0] || below[1]);
  endsequence
  sequence unpark_cause_s;
    clk_en && port_powered[0] && port_in[0].single_sig && !st_reg.cfg[fpfp_pkg::DCDT_LSB]
      && st_reg.parked[1] && chan_in[0].current > fpfp_pkg::CUR_CODE_75;
  endsequence

  // Register reset and host writes
  reset_zero_a: assert property (@(posedge mclk)
    !rst_n |=> cmd_rdata == 8'h00 && st_reg.cfg == 8'h00)
    else $error("config not cleared by reset");
  write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && cmd_wr && cmd_code == fpfp_pkg::CMD_FAULT_CFG && !(|port_in[0].turn_on)
    && !port_in[1].turn_on |=> st_reg.cfg == $past(cmd_wdata))
    else $error("config write lost");

  // Fault shutdown policy
  current_limit_fault_both_a: assert property (@(posedge mclk) disable iff (!rst_n)
    current_limit_fault_hit_s(0) |=> chan_disable[1]) else $error("partner not shut on current_limit_fault");
  current_limit_fault_any_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_powered[1] && chan_in[2].current_limit_fault_fault |=> chan_disable[2])
    else $error("current_limit_fault fault ignored");
  pcut_both_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_powered[0] && chan_in[1].pcut_fault && st_reg.cfg[fpfp_pkg::PCUT_LSB]
    |=> chan_disable[0]) else $error("partner not shut on pcut");

  // Turn-on automatic settings
  sum_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_in[0].turn_on && port_in[0].single_sig |=> st_reg.cfg[fpfp_pkg::SUM_LSB])
    else $error("summed policing not forced");
  auto_pol_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_in[1].turn_on && port_in[1].single_sig && port_in[1].auto_mode
    |=> st_reg.cfg[7] && st_reg.cfg[5]) else $error("auto policy bits not set");
  dual_dcdt_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_in[0].turn_on && !port_in[0].single_sig |=> st_reg.cfg[0])
    else $error("dual threshold bit not set");
  class_dcdt_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_in[0].turn_on && port_in[0].single_sig
    |=> st_reg.cfg[0] == ($past(port_in[0].class_assigned) >= 4'h5))
    else $error("class threshold wrong");

  // Disconnect handling per signature type
  dual_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_powered[1] && !port_in[1].single_sig && qualified[2] |=> chan_disable[2])
    else $error("dual channel not dropped");
  park_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
    park_cause_s |=> chan_disable[1]) else $error("low class channel not parked");
  unpark_a: assert property (@(posedge mclk) disable iff (!rst_n)
    unpark_cause_s |=> !st_reg.parked[1]) else $error("parked channel not restored");
  both_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && port_powered[0] && port_in[0].single_sig && st_reg.cfg[fpfp_pkg::DCDT_LSB]
    && qualified[0] && qualified[1] |=> chan_disable[1:0] == 2'b11)
    else $error("high class pair not dropped together");
endmodule

//--- dv/fpfp_host.sv
// Host model: command-byte writes and reads of the fault config register
module fpfp_host (
  input wire logic mclk,
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial
  begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_wdata = 8'h00;
  end
  // One-byte write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(negedge mclk);
    cmd_code = code;
    cmd_wdata = data;
    cmd_wr = 1'b1;
    @(negedge mclk);
    cmd_wr = 1'b0;
    cmd_wdata = ~data; // Released data no longer shows the last value
  endtask
  // One-byte read: data is registered on the edge after the code
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(negedge mclk);
    cmd_code = code;
    @(negedge mclk);
    data = cmd_rdata;
  endtask
endmodule

//--- dv/fpfp_core_tb.sv
// Self-checking bench for the four-pair fault policy core
module fpfp_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] cfg;
    logic [1:0] ch;
    logic [1:0] k;
    logic [3:0] exp;
  } fpfp_row_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, rd;
  logic cmd_wr;
  fpfp_pkg::fpfp_port_s [1:0] port_in = '0;
  logic [1:0] port_powered = 2'b00;
  fpfp_pkg::fpfp_chan_s [3:0] chan_in = {4{11'h080}};
  logic [3:0] chan_disable, chan_low_current;
  int failures = 0;
  int samples_checked = 0;
  int n;
  // Fault rows: config, channel, kind (current_limit_fault, pcut, summed), expected disables
  fpfp_row_s rows [10] = '{'{8'h40, 2'h0, 2'h0, 4'h3}, '{8'h00, 2'h1, 2'h0, 4'h2},
    '{8'h80, 2'h3, 2'h0, 4'hc}, '{8'h40, 2'h2, 2'h0, 4'h4}, '{8'h10, 2'h1, 2'h1, 4'h3},
    '{8'h20, 2'h2, 2'h1, 4'hc}, '{8'h00, 2'h0, 2'h1, 4'h1}, '{8'h0c, 2'h0, 2'h0, 4'h1},
    '{8'h04, 2'h1, 2'h2, 4'h3}, '{8'h00, 2'h1, 2'h2, 4'h0}};
  always #50 mclk = ~mclk;
  fpfp_host u_fpfp_host (.mclk(mclk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata));
  fpfp_core u_fpfp_core (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .port_in(port_in),
    .port_powered(port_powered), .chan_in(chan_in), .chan_disable(chan_disable),
    .chan_low_current(chan_low_current));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Turn-on pulse with auto mode, then read back the config
  task automatic pulse_on(input int p, input logic ss, input logic [3:0] cls, input logic [7:0] e);
    @(negedge mclk);
    port_in[p] = {1'b1, 1'b1, ss, cls};
    @(negedge mclk);
    port_in[p].turn_on = 1'b0;
    u_fpfp_host.rd(fpfp_pkg::CMD_FAULT_CFG, rd);
    chk(rd, e);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    u_fpfp_host.rd(fpfp_pkg::CMD_FAULT_CFG, rd);
    chk(rd, fpfp_pkg::FAULT_CFG_RESET);
    u_fpfp_host.wr(8'h2c, 8'hff);
    u_fpfp_host.rd(fpfp_pkg::CMD_FAULT_CFG, rd);
    chk(rd, 8'h00);
    u_fpfp_host.rd(8'h2c, rd);
    chk(rd, 8'h00);
    foreach (rows[i])
    begin
      u_fpfp_host.wr(fpfp_pkg::CMD_FAULT_CFG, rows[i].cfg);
      u_fpfp_host.rd(fpfp_pkg::CMD_FAULT_CFG, rd);
      chk(rd, rows[i].cfg);
      port_powered = 2'b11;
      chan_in[rows[i].ch][10 - rows[i].k] = 1'b1;
      @(negedge mclk);
      chan_in[rows[i].ch][10 - rows[i].k] = 1'b0;
      @(negedge mclk);
      chk({4'h0, chan_disable}, {4'h0, rows[i].exp});
      port_powered = 2'b00;
    end
    u_fpfp_host.wr(fpfp_pkg::CMD_FAULT_CFG, 8'h01);
    port_powered = 2'b11;
    pulse_on(0, 1'b1, 4'h2, 8'h54);
    pulse_on(1, 1'b1, 4'h5, 8'hfe);
    u_fpfp_host.wr(fpfp_pkg::CMD_FAULT_CFG, 8'h00);
    pulse_on(1, 1'b0, 4'h5, 8'h02);
    // Dual signature: only the starved channel drops, after the full window
    port_powered = 2'b10;
    chan_in[2].current = 8'h04;
    chan_in[3].current = 8'h30;
    repeat (fpfp_pkg::QUAL_CYC - 5) @(negedge mclk);
    chk({4'h0, chan_disable}, 8'h00);
    n = 0;
    while (chan_disable[2] !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 20)
    begin
      failures++;
      $display("[FAIL] t=%0t wait timeout got=%h exp=%h", $time, chan_disable, 4'h4);
    end
    chk({4'h0, chan_disable}, 8'h04);
    chk({4'h0, chan_low_current}, 8'h04);
    // Low-class single signature: odd channel parked at once, back when channel 0 goes above 75 mA
    port_powered = 2'b11;
    chan_in[0].current = 8'h04;
    @(negedge mclk);
    chk({4'h0, chan_disable}, 8'h06);
    chan_in[0].current = 8'hff;
    @(negedge mclk);
    chk({4'h0, chan_disable}, 8'h04);
    // High-class single signature: one low channel keeps both powered
    u_fpfp_host.wr(fpfp_pkg::CMD_FAULT_CFG, 8'h03);
    chan_in[0].current = 8'h04;
    repeat (fpfp_pkg::QUAL_CYC + 2) @(negedge mclk);
    chk({6'h00, chan_disable[1:0]}, 8'h00);
    chk({6'h00, chan_low_current[1:0]}, 8'h01);
    chan_in[1].current = 8'h04;
    repeat (fpfp_pkg::QUAL_CYC + 2) @(negedge mclk);
    chk({6'h00, chan_disable[1:0]}, 8'h03);
    chk({6'h00, chan_low_current[1:0]}, 8'h03);
    // Reset in mid-run clears everything; a frozen clock enable drops writes
    port_powered = 2'b00;
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk({4'h0, chan_disable}, 8'h00);
    clk_en = 1'b0;
    u_fpfp_host.wr(fpfp_pkg::CMD_FAULT_CFG, 8'ha5);
    clk_en = 1'b1;
    u_fpfp_host.rd(fpfp_pkg::CMD_FAULT_CFG, rd);
    chk(rd, fpfp_pkg::FAULT_CFG_RESET);
    final_report();
  end
endmodule
